//--- src/gmp_cfg.svh
// Purpose: Offsets, field positions, reset values and group layout of the pin block.
// Assumes: Four registers on a small byte-wide register port with a 4-bit address.
// Notes: Most figures live here; the soft reset read-back bit and the modem ready-out enable are also written as literals.
`ifndef GMP_CFG_SVH
`define GMP_CFG_SVH

`define GMP_ADDR_W 4
`define GMP_OFF_DIR 4'h0
`define GMP_OFF_LEVEL 4'h1
`define GMP_OFF_IRQEN 4'h2
`define GMP_OFF_CTRL 4'h3

`define GMP_CTL_LATCH 0
`define GMP_CTL_GRP_HI 1
`define GMP_CTL_GRP_LO 2
`define GMP_CTL_SRST 3
`define GMP_CTL_KEEP_MASK 8'h07
`define GMP_RST_BYTE 8'h00

`define GMP_POS_DSR 0
`define GMP_POS_DTR 1
`define GMP_POS_CD 2
`define GMP_POS_RI 3

`endif

//--- src/gmp_pkg.sv
// Purpose: Types shared by the pin control block and its modem group mapper.
// Assumes: Constants come from gmp_cfg.svh.
// Notes: Modem status fields are active high, i.e. the inverse of the low-active pins.
package gmp_pkg;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } gmp_reg_req_type;

    typedef struct packed {
        logic carrier_in;
        logic bell_in;
        logic peer_ready_in;
    } gmp_modem_type;

    typedef enum logic [1:0] {
        SR_IDLE = 2'b01,
        SR_ACTIVE = 2'b10
    } gmp_srst_state_type;

endpackage : gmp_pkg

//--- src/gmp_modem_group.sv
// Purpose: Emulates one channel's ring, carrier, ready-in and ready-out lines on four pins.
// Assumes: Pins are low active; reset is the block's combined hardware or soft reset.
// Notes: Status and change outputs are zero while the group is in general I/O mode.
`include "gmp_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module gmp_modem_group (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [3:0] pins_in,
    input wire logic modem_en,
    input wire logic dtr_ctl,
    input wire logic msi_en,
    output gmp_pkg::gmp_modem_type status,
    output gmp_pkg::gmp_modem_type delta,
    output logic irq_pulse,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe
);
    gmp_pkg::gmp_modem_type status_q;
    gmp_pkg::gmp_modem_type status_d;
    gmp_pkg::gmp_modem_type delta_q;
    gmp_pkg::gmp_modem_type delta_d;
    logic en_q;
    logic irq_q;
    logic irq_d;

    // [R15] Status mirrors pins
    // [R12] Zero in I/O mode
    assign status_d = modem_en ? gmp_pkg::gmp_modem_type'{
        carrier_in: ~pins_in[`GMP_POS_CD],
        bell_in: ~pins_in[`GMP_POS_RI],
        peer_ready_in: ~pins_in[`GMP_POS_DSR]} : '0;
    // A change seen right after the mode switch is the switch itself, not the line.
    // [R13] No change in I/O mode
    assign delta_d = (modem_en && en_q) ? (status_d ^ status_q) : '0;
    // [R17] Change raises interrupt
    assign irq_d = msi_en && (delta_d != '0);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            status_q <= '0;
            delta_q <= '0;
            en_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            status_q <= status_d;
            delta_q <= delta_d;
            en_q <= modem_en;
            irq_q <= irq_d;
        end
    end

    assign status = status_q;
    assign delta = delta_q;
    assign irq_pulse = irq_q;
    // [R16] Control bit drives ready-out
    assign pin_out = modem_en ? {2'b00, ~dtr_ctl, 1'b0} : 4'h0;
    assign pin_oe = modem_en ? 4'h2 : 4'h0;
endmodule : gmp_modem_group
`default_nettype wire

//--- src/gmp_pin_ctrl.sv
// Purpose: Eight programmable pins with input capture, pin-change interrupt and modem emulation.
// Assumes: Register requests are one-cycle strobes synchronous to clk_sys.
// Notes: Read data appears one cycle after the read strobe; pins 3:0 map to channel B.
`include "gmp_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// [R01] Writing control bit 3 resets whole device
// [R02] Soft reset bit returns to zero itself
// [R03] Bit 2 makes low pins channel B modem
// [R04] Bit 1 makes high pins channel A modem
// [R05] Control bits 7:4 reserved, no function
// [R06] Unlatched: change interrupts, state read clears
// [R07] Unlatched: reverting input clears pending interrupt
// [R08] Latched: change interrupts and captures level
// [R09] Latched: state read clears pending interrupt
// [R10] Latched: revert keeps interrupt and captured level
// [R11] I/O pins governed by pin registers
// [R12] I/O mode hides pins from modem status
// [R13] I/O mode raises no modem interrupt
// [R14] I/O mode: modem control ignores ready-out
// [R15] Modem mode reports pin levels in status
// [R16] Modem mode: control bit drives ready-out
// [R17] Modem mode: enabled changes raise modem interrupt
// [R18] Modem mode: pin registers have no effect
// [R19] Direction bit: zero input, one output
// [R20] State write drives outputs, read returns levels
// [R21] Per-pin enable gates change interrupt
// [R22] Control register zero after any reset
module gmp_pin_ctrl #(
    parameter int PIN_COUNT = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire gmp_pkg::gmp_reg_req_type reg_req,
    output logic [7:0] rd_data,
    input wire logic [PIN_COUNT-1:0] gpio_in,
    output logic [PIN_COUNT-1:0] gpio_out,
    output logic [PIN_COUNT-1:0] gpio_oe,
    output logic gpio_irq,
    input wire logic [1:0] modem_ctl_dtr,
    input wire logic [1:0] irq_mask_msi,
    output gmp_pkg::gmp_modem_type modem_state_chan_a,
    output gmp_pkg::gmp_modem_type modem_state_chan_b,
    output gmp_pkg::gmp_modem_type modem_delta_chan_a,
    output gmp_pkg::gmp_modem_type modem_delta_chan_b,
    output logic [1:0] modem_irq,
    output logic dev_soft_rst
);
    localparam int GRP = PIN_COUNT / 2;

    gmp_pkg::gmp_srst_state_type srst_q;
    gmp_pkg::gmp_srst_state_type srst_d;
    logic blk_rst;
    logic [7:0] pin_direction_reg_q;
    logic [7:0] pin_level_reg_q;
    logic [7:0] pin_change_irq_enable_q;
    logic [7:0] io_pin_control_q;
    logic [7:0] io_pin_control_d;
    logic [7:0] rd_data_q;
    logic [7:0] rd_data_d;
    logic [PIN_COUNT-1:0] ref_q;
    logic [PIN_COUNT-1:0] ref_d;
    logic [PIN_COUNT-1:0] pend_q;
    logic [PIN_COUNT-1:0] pend_d;
    logic [PIN_COUNT-1:0] cap_q;
    logic [PIN_COUNT-1:0] cap_d;
    logic [PIN_COUNT-1:0] gpio_out_q;
    logic [PIN_COUNT-1:0] gpio_oe_q;
    logic [PIN_COUNT-1:0] gpio_out_d;
    logic [PIN_COUNT-1:0] gpio_oe_d;
    logic [PIN_COUNT-1:0] pin_is_io;
    logic [PIN_COUNT-1:0] elig;
    logic [PIN_COUNT-1:0] chg_set;
    logic [PIN_COUNT-1:0] level_view;
    logic [GRP-1:0] mdm_out_lo;
    logic [GRP-1:0] mdm_oe_lo;
    logic [GRP-1:0] mdm_out_hi;
    logic [GRP-1:0] mdm_oe_hi;
    logic wr_dir;
    logic wr_level;
    logic wr_irqen;
    logic wr_ctrl;
    logic rd_level;
    logic latch_en;
    logic modem_lo;
    logic modem_hi;

    assign wr_dir = reg_req.wr && (reg_req.addr == `GMP_OFF_DIR);
    assign wr_level = reg_req.wr && (reg_req.addr == `GMP_OFF_LEVEL);
    assign wr_irqen = reg_req.wr && (reg_req.addr == `GMP_OFF_IRQEN);
    assign wr_ctrl = reg_req.wr && (reg_req.addr == `GMP_OFF_CTRL);
    assign rd_level = reg_req.rd && (reg_req.addr == `GMP_OFF_LEVEL);

    // [R01] Soft reset request
    assign srst_d = (srst_q == gmp_pkg::SR_IDLE && wr_ctrl && reg_req.wdata[`GMP_CTL_SRST])
        ? gmp_pkg::SR_ACTIVE : gmp_pkg::SR_IDLE;
    // [R01] Whole-device reset source
    assign blk_rst = rst || (srst_q == gmp_pkg::SR_ACTIVE);
    assign dev_soft_rst = (srst_q == gmp_pkg::SR_ACTIVE);

    // [R02] Bit clears itself
    // The sequencer answers only to the hardware reset, so the soft reset ends by itself.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            srst_q <= gmp_pkg::SR_IDLE;
        end else begin
            srst_q <= srst_d;
        end
    end

    // [R05] Reserved bits never stored
    assign io_pin_control_d = wr_ctrl ? (reg_req.wdata & `GMP_CTL_KEEP_MASK) : io_pin_control_q;
    assign latch_en = io_pin_control_q[`GMP_CTL_LATCH];
    // [R03] Low group mode select
    assign modem_lo = io_pin_control_q[`GMP_CTL_GRP_LO];
    // [R04] High group mode select
    assign modem_hi = io_pin_control_q[`GMP_CTL_GRP_HI];

    always_ff @(posedge clk_sys) begin
        // [R22] All zero after any reset
        if (blk_rst) begin
            pin_direction_reg_q <= `GMP_RST_BYTE;
            pin_level_reg_q <= `GMP_RST_BYTE;
            pin_change_irq_enable_q <= `GMP_RST_BYTE;
            io_pin_control_q <= `GMP_RST_BYTE;
        end else begin
            if (wr_dir) begin
                pin_direction_reg_q <= reg_req.wdata;
            end
            if (wr_level) begin
                pin_level_reg_q <= reg_req.wdata;
            end
            if (wr_irqen) begin
                pin_change_irq_enable_q <= reg_req.wdata;
            end
            io_pin_control_q <= io_pin_control_d;
        end
    end

    gmp_modem_group u_grp_b (
        .clk_sys(clk_sys),
        .rst(blk_rst),
        .pins_in(gpio_in[GRP-1:0]),
        .modem_en(modem_lo),
        .dtr_ctl(modem_ctl_dtr[0]),
        .msi_en(irq_mask_msi[0]),
        .status(modem_state_chan_b),
        .delta(modem_delta_chan_b),
        .irq_pulse(modem_irq[0]),
        .pin_out(mdm_out_lo),
        .pin_oe(mdm_oe_lo)
    );

    gmp_modem_group u_grp_a (
        .clk_sys(clk_sys),
        .rst(blk_rst),
        .pins_in(gpio_in[PIN_COUNT-1:GRP]),
        .modem_en(modem_hi),
        .dtr_ctl(modem_ctl_dtr[1]),
        .msi_en(irq_mask_msi[1]),
        .status(modem_state_chan_a),
        .delta(modem_delta_chan_a),
        .irq_pulse(modem_irq[1]),
        .pin_out(mdm_out_hi),
        .pin_oe(mdm_oe_hi)
    );

    genvar i;
    generate
        for (i = 0; i < PIN_COUNT; i++) begin : g_pin
            // [R11] Pin registers govern I/O pins
            assign pin_is_io[i] = (i < GRP) ? ~modem_lo : ~modem_hi;
            // [R21] Enabled input pins only
            assign elig[i] = pin_is_io[i] && !pin_direction_reg_q[i] && pin_change_irq_enable_q[i];
            // [R08] Capture on first change
            assign chg_set[i] = elig[i] && latch_en && !pend_q[i] && (gpio_in[i] != ref_q[i]);
            // [R10] Captured level shown while pending
            assign level_view[i] = (latch_en && pend_q[i]) ? cap_q[i] : gpio_in[i];
            // The reference becomes what the read returned, so a level that moved
            // after the capture raises a fresh interrupt right after the read.
            assign ref_d[i] = !elig[i] ? gpio_in[i] : (rd_level ? level_view[i] : ref_q[i]);
            // [R06] Unlatched pending follows compare
            // [R07] Revert clears it
            // [R09] Latched read clears
            assign pend_d[i] = !elig[i] ? 1'b0 :
                (!latch_en ? (gpio_in[i] != ref_d[i]) :
                (chg_set[i] || (pend_q[i] && !rd_level)));
            assign cap_d[i] = chg_set[i] ? gpio_in[i] : cap_q[i];
            // [R18] Modem pins ignore pin registers
            // [R19] Direction sets drive
            // [R20] Written level to output pins
            // [R14] Ready-out only from group mapper
            assign gpio_oe_d[i] = pin_is_io[i] ? pin_direction_reg_q[i]
                : ((i < GRP) ? mdm_oe_lo[i % GRP] : mdm_oe_hi[i % GRP]);
            assign gpio_out_d[i] = pin_is_io[i] ? (pin_direction_reg_q[i] && pin_level_reg_q[i])
                : ((i < GRP) ? mdm_out_lo[i % GRP] : mdm_out_hi[i % GRP]);
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (blk_rst) begin
            ref_q <= '0;
            pend_q <= '0;
            cap_q <= '0;
            gpio_out_q <= '0;
            gpio_oe_q <= '0;
        end else begin
            ref_q <= ref_d;
            pend_q <= pend_d;
            cap_q <= cap_d;
            gpio_out_q <= gpio_out_d;
            gpio_oe_q <= gpio_oe_d;
        end
    end

    // [R20] Read returns pin levels
    // [R02] Soft reset bit reads back
    assign rd_data_d = !reg_req.rd ? 8'h00 :
        (reg_req.addr == `GMP_OFF_DIR) ? pin_direction_reg_q :
        (reg_req.addr == `GMP_OFF_LEVEL) ? level_view :
        (reg_req.addr == `GMP_OFF_IRQEN) ? pin_change_irq_enable_q :
        (reg_req.addr == `GMP_OFF_CTRL) ? (io_pin_control_q | {4'h0, dev_soft_rst, 3'h0}) :
        8'h00;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_data_q <= 8'h00;
        end else begin
            rd_data_q <= rd_data_d;
        end
    end

    assign rd_data = rd_data_q;
    assign gpio_out = gpio_out_q;
    assign gpio_oe = gpio_oe_q;
    assign gpio_irq = |pend_q;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    a_srst_one_cycle: assert property ( // [R01]
        (srst_q == gmp_pkg::SR_IDLE && wr_ctrl && reg_req.wdata[`GMP_CTL_SRST])
        |=> dev_soft_rst ##1 !dev_soft_rst)
        else $error("soft reset did not last exactly one cycle");

    a_srst_self_clear: assert property ( // [R02]
        dev_soft_rst ##1 (reg_req.rd && reg_req.addr == `GMP_OFF_CTRL)
        |=> !rd_data[`GMP_CTL_SRST])
        else $error("soft reset bit did not return to zero");

    a_ctrl_after_reset: assert property ( // [R22]
        dev_soft_rst |=> (io_pin_control_q == 8'h00 && pend_q == '0))
        else $error("control or pending state not cleared by soft reset");

    a_reserved_zero: assert property ( // [R05]
        (reg_req.rd && reg_req.addr == `GMP_OFF_CTRL) |=> rd_data[7:4] == 4'h0)
        else $error("reserved control bits read non-zero");

    a_dtr_follows_ctl: assert property ( // [R16]
        (modem_hi && !dev_soft_rst) ##1 (modem_hi && !dev_soft_rst)
        |-> gpio_oe[GRP+`GMP_POS_DTR] && gpio_out[GRP+`GMP_POS_DTR] == !$past(modem_ctl_dtr[1]))
        else $error("ready-out pin does not follow modem control");

    a_io_status_hidden: assert property ( // [R12]
        (!modem_lo && !$past(modem_lo)) |-> modem_state_chan_b == '0 && modem_irq[0] == 1'b0)
        else $error("modem status visible in general I/O mode");

    a_unlatched_revert: assert property ( // [R07]
        (elig[4] && !latch_en && !rd_level && gpio_in[4] == ref_q[4]) |=> !pend_q[4])
        else $error("unlatched pending not cleared on revert");

    a_unlatched_set: assert property ( // [R06]
        (elig[4] && !latch_en && !rd_level && !dev_soft_rst && gpio_in[4] != ref_q[4])
        |=> pend_q[4])
        else $error("unlatched pin change did not raise pending");

    a_latched_capture: assert property ( // [R08]
        (chg_set[5] && !dev_soft_rst) |=> pend_q[5] && cap_q[5] == $past(gpio_in[5]))
        else $error("latched pin change not captured");

    a_latched_hold: assert property ( // [R10]
        (pend_q[5] && latch_en && elig[5] && !rd_level && !wr_ctrl && !dev_soft_rst)
        |=> pend_q[5] && cap_q[5] == $past(cap_q[5]))
        else $error("latched interrupt or level lost before read");

    a_latched_read_clear: assert property ( // [R09]
        (pend_q[5] && latch_en && rd_level && !dev_soft_rst) |=> !pend_q[5])
        else $error("state read did not clear latched pending");

    a_direction_input: assert property ( // [R19]
        (pin_is_io[4] && !pin_direction_reg_q[4]) |=> !gpio_oe[4])
        else $error("input pin is driven");

    a_modem_pin_input: assert property ( // [R18]
        modem_hi |=> !gpio_oe[GRP+`GMP_POS_CD])
        else $error("modem carrier pin driven from pin registers");

    a_io_no_modem_irq: assert property ( // [R13]
        !modem_hi |=> !modem_irq[1])
        else $error("modem interrupt raised in general I/O mode");

    a_output_level: assert property ( // [R20]
        (pin_is_io[1] && pin_direction_reg_q[1] && !blk_rst) |=> gpio_oe[1] && gpio_out[1] == $past(pin_level_reg_q[1]))
        else $error("output pin not driven to written level");
endmodule : gmp_pin_ctrl
`default_nettype wire

//--- tb/gmp_pin_model.sv
// Purpose: Models the external lines on the eight pins.
// Assumes: No pin has a pull-up, so a released line reads the external level ext_level.
// Notes: A pin that the block drives reads back the block's own level.
`timescale 1ns/1ns
`default_nettype none
module gmp_pin_model (
    input wire logic [7:0] ext_level,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    output logic [7:0] pin_level
);
    // The block's drive wins wherever its enable is high.
    assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : gmp_pin_model
`default_nettype wire

//--- tb/gmp_pin_ctrl_tb.sv
// Purpose: Self-checking bench for the pin control block.
// Assumes: Outputs are sampled 1 ns after the clock edge, except rd_data, which the monitor samples at the edge.
// Notes: Read data is checked by a monitor against a queue of expected bytes.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, a) \
    begin \
        num_checks++; \
        if ((e) !== (a)) begin \
            n_errors++; \
            $display("ERROR %s expected %0h seen %0h", nm, e, a); \
        end \
    end
module gmp_pin_ctrl_tb;
    logic clk_sys;
    logic rst;
    gmp_pkg::gmp_reg_req_type req;
    logic [7:0] rd_data;
    logic [7:0] gpio_in;
    logic [7:0] gpio_out;
    logic [7:0] gpio_oe;
    logic gpio_irq;
    logic [1:0] dtr;
    logic [1:0] msi;
    gmp_pkg::gmp_modem_type st_a;
    gmp_pkg::gmp_modem_type st_b;
    gmp_pkg::gmp_modem_type dl_a;
    gmp_pkg::gmp_modem_type dl_b;
    logic [2:0] da;
    logic [2:0] db;
    logic [1:0] modem_irq;
    logic soft_rst;
    logic [7:0] ext;
    logic [7:0] lvl;
    logic [7:0] exp_v;
    logic rd_pend;
    logic [15:0] seed;
    logic [7:0] exp_q[$];
    int n_errors;
    int num_checks;
    int cyc;
    int na;
    int nb;
    int ns;

    gmp_pin_ctrl uut (
        .clk_sys(clk_sys), .rst(rst), .reg_req(req), .rd_data(rd_data),
        .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_irq(gpio_irq),
        .modem_ctl_dtr(dtr), .irq_mask_msi(msi), .modem_state_chan_a(st_a),
        .modem_state_chan_b(st_b), .modem_delta_chan_a(dl_a), .modem_delta_chan_b(dl_b),
        .modem_irq(modem_irq), .dev_soft_rst(soft_rst)
    );

    gmp_pin_model lines (
        .ext_level(ext), .pin_out(gpio_out), .pin_oe(gpio_oe), .pin_level(gpio_in)
    );

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys);
        req <= '0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        exp_q.push_back(e);
        @(posedge clk_sys);
        req <= '0;
    endtask : rd

    // Counts one-cycle pulses over five cycles, starting just after the current edge.
    task automatic pulses();
        na = 0;
        nb = 0;
        ns = 0;
        da = 3'h0;
        db = 3'h0;
        repeat (5) begin
            #1;
            na += int'(modem_irq[1] === 1'b1);
            nb += int'(modem_irq[0] === 1'b1);
            ns += int'(soft_rst === 1'b1);
            da = da | dl_a;
            db = db | dl_b;
            @(posedge clk_sys);
        end
        // Leaves the caller just past an edge, where the outputs have settled.
        #1;
    endtask : pulses

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (rd_pend) begin
            exp_v = exp_q.pop_front();
            `CHK("rd_data", exp_v, rd_data)
        end
        rd_pend <= req.rd && !rst;
    end

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            $display("ERROR cycle_limit expected 0 seen 1");
            give_verdict();
        end
    end

    initial begin
        rst = 1'b1;
        req = '0;
        ext = 8'hFF;
        dtr = 2'b00;
        msi = 2'b00;
        seed = 16'h189A;
        n_errors = 0;
        num_checks = 0;
        cyc = 0;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        rd(4'h3, 8'h00);
        wr(4'h9, 8'hFF);
        rd(4'h9, 8'h00);
        seed = lfsr_next(seed);
        lvl = seed[7:0];
        wr(4'h0, 8'h0F);
        wr(4'h1, lvl);
        tick(3);
        `CHK("gpio_oe", 8'h0F, gpio_oe)
        `CHK("gpio_out", lvl[3:0], gpio_out[3:0])
        rd(4'h1, {ext[7:4], lvl[3:0]});
        wr(4'h2, 8'hF0);
        @(posedge clk_sys);
        ext <= 8'hEF;
        tick(3);
        `CHK("gpio_irq", 1'b1, gpio_irq)
        @(posedge clk_sys);
        ext <= 8'hFF;
        tick(3);
        `CHK("gpio_irq", 1'b0, gpio_irq)
        @(posedge clk_sys);
        ext <= 8'hEF;
        tick(3);
        rd(4'h1, {4'hE, lvl[3:0]});
        tick(2);
        `CHK("gpio_irq", 1'b0, gpio_irq)
        wr(4'h3, 8'h01);
        @(posedge clk_sys);
        ext <= 8'hCF;
        tick(3);
        @(posedge clk_sys);
        ext <= 8'hEF;
        tick(3);
        `CHK("gpio_irq", 1'b1, gpio_irq)
        rd(4'h1, {4'hC, lvl[3:0]});
        tick(3);
        rd(4'h1, {4'hE, lvl[3:0]});
        tick(3);
        `CHK("gpio_irq", 1'b0, gpio_irq)
        wr(4'h3, 8'hF2);
        rd(4'h3, 8'h02);
        wr(4'h0, 8'hF0);
        @(posedge clk_sys);
        dtr <= 2'b11;
        msi <= 2'b11;
        tick(3);
        `CHK("gpio_oe", 8'h20, gpio_oe)
        `CHK("gpio_out5", 1'b0, gpio_out[5])
        @(posedge clk_sys);
        ext <= 8'hAB;
        pulses();
        `CHK("modem_irq_a", 1, na)
        `CHK("modem_irq_b", 0, nb)
        `CHK("delta_a", 3'h4, da)
        `CHK("delta_b", 3'h0, db)
        `CHK("state_a", 3'h5, st_a)
        `CHK("state_b", 3'h0, st_b)
        `CHK("gpio_irq", 1'b0, gpio_irq)
        wr(4'h3, 8'h0A);
        pulses();
        `CHK("soft_rst", 1, ns)
        rd(4'h3, 8'h00);
        tick(1);
        `CHK("gpio_oe", 8'h00, gpio_oe)
        `CHK("state_a", 3'h0, st_a)
        wr(4'h3, 8'h04);
        rd(4'h3, 8'h04);
        tick(3);
        `CHK("gpio_oe", 8'h02, gpio_oe)
        `CHK("gpio_out1", 1'b0, gpio_out[1])
        `CHK("state_b", 3'h4, st_b)
        @(posedge clk_sys);
        ext <= 8'h53;
        dtr <= 2'b10;
        pulses();
        `CHK("modem_irq_b", 1, nb)
        `CHK("modem_irq_a", 0, na)
        `CHK("delta_b", 3'h2, db)
        `CHK("state_b", 3'h6, st_b)
        `CHK("state_a", 3'h0, st_a)
        `CHK("gpio_out1", 1'b1, gpio_out[1])
        wr(4'h3, 8'h08);
        rd(4'h3, 8'h00);
        tick(2);
        `CHK("gpio_oe", 8'h00, gpio_oe)
        `CHK("state_b", 3'h0, st_b)
        tick(2);
        give_verdict();
    end
endmodule : gmp_pin_ctrl_tb
`default_nettype wire
